// >>> hw/pattern_pkg.sv
// package: constants and types of the logic pattern generator
package pattern_pkg;
  localparam int unsigned lane_count = 16;
  localparam int unsigned mem_depth = 16384;
  localparam int unsigned addr_width = 14;
  localparam int unsigned clock_period_ps = 5000;
  localparam int unsigned osc_mhz = 50;
  localparam int unsigned core_mhz = 200;
  // register offsets on the 16-bit bus (word addresses)
  localparam logic [7:0] reg_ctrl = 8'h00;
  localparam logic [7:0] reg_status = 8'h01;
  localparam logic [7:0] reg_initial = 8'h02;
  localparam logic [7:0] reg_length = 8'h03;
  localparam logic [7:0] reg_interval_lo = 8'h04;
  localparam logic [7:0] reg_interval_hi = 8'h05;
  localparam logic [7:0] reg_mem_addr = 8'h06;
  localparam logic [7:0] reg_mem_data = 8'h07;
  localparam logic [7:0] reg_position = 8'h08;
  // control register fields
  localparam int unsigned ctrl_start_bit = 0;
  localparam int unsigned ctrl_stop_bit = 1;
  localparam int unsigned ctrl_cyclic_bit = 2;
  // reset values and interval limit
  localparam logic [15:0] initial_reset = 16'h0000;
  localparam logic [14:0] length_reset = 15'h0001;
  localparam logic [31:0] interval_reset = 32'h0000_0001;
  localparam logic [31:0] interval_max = 32'h8000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run = 2'b10
  } play_state_type;
endpackage

// >>> hw/logic_pattern_unit.sv
// logic pattern generator: pattern memory, playback sequencer and register port
`timescale 1ns/1ps
`default_nettype none

// Function
// - drive sixteen output lanes, each one logic state at a time
// - lanes are plain two-valued outputs, never tristated
// - pattern memory of 16K words, sixteen bits each
// - sample bit n drives lane n
// - play samples from consecutive memory addresses in order
// - segment length programmable up to 16K samples
// - one-shot and cyclic playback modes selectable
// - one-shot stops after last sample and holds it
// - cyclic restarts at first sample with no gap
// - programmable initial sample shown before first start and from each start until first step
// - samples step after a programmed interval in 5 ns clocks
// - interval from one clock up to 2^31 clocks
// - logic runs on the 200 MHz core clock from 50 MHz oscillator
// - registers exchanged over a 16-bit parallel bus
// - all settings held in software-visible registers that steer the block
// - runs alongside other functions; lanes only reach pins via the mux
module logic_pattern_unit #(
  parameter int unsigned depth = pattern_pkg::mem_depth,
  parameter int unsigned aw = pattern_pkg::addr_width
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire pattern_pkg::bus_req_type bus_req,
  output logic [15:0] bus_rdata,
  output logic [15:0] pattern_lane_out,
  output logic busy
);
  import pattern_pkg::*;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] initial_q;
  logic [14:0] length_q;
  logic [31:0] interval_q;
  logic cyclic_q;
  logic [aw-1:0] mem_addr_q;
  logic [15:0] mem [depth];
  logic start_pulse;
  logic stop_pulse;
  logic wr_ctrl;

  // the clock is assumed to come from the core pll
  assign wr_ctrl = bus_req.wr && bus_req.addr == reg_ctrl;
  assign start_pulse = clk_en && wr_ctrl && bus_req.wdata[ctrl_start_bit];
  assign stop_pulse = clk_en && wr_ctrl && bus_req.wdata[ctrl_stop_bit];

  // settings steer the sequencer over the 16-bit port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      initial_q <= initial_reset;
      length_q <= length_reset;
      interval_q <= interval_reset;
      cyclic_q <= 1'b0;
    end else if (clk_en && bus_req.wr) begin
      if (bus_req.addr == reg_ctrl) begin
        cyclic_q <= bus_req.wdata[ctrl_cyclic_bit];
      end else if (bus_req.addr == reg_initial) begin
        initial_q <= bus_req.wdata;
      end else if (bus_req.addr == reg_length) begin
        // zero and oversize values clamp into 1..depth
        if (bus_req.wdata[14:0] == 15'h0000) begin
          length_q <= 15'h0001;
        end else if (bus_req.wdata[14:0] > 15'(depth)) begin
          length_q <= 15'(depth);
        end else begin
          length_q <= bus_req.wdata[14:0];
        end
      end else if (bus_req.addr == reg_interval_lo) begin
        interval_q[15:0] <= bus_req.wdata;
      end else if (bus_req.addr == reg_interval_hi) begin
        interval_q[31:16] <= bus_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // pattern memory
  // ---------------------------------------------------------------
  // the load address auto-increments so a segment streams in word by word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_addr_q <= '0;
    end else if (clk_en && bus_req.wr) begin
      if (bus_req.addr == reg_mem_addr) begin
        mem_addr_q <= bus_req.wdata[aw-1:0];
      end else if (bus_req.addr == reg_mem_data) begin
        mem_addr_q <= mem_addr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && bus_req.wr && bus_req.addr == reg_mem_data) begin
      mem[mem_addr_q] <= bus_req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // playback sequencer
  // ---------------------------------------------------------------
  play_state_type state_q;
  logic [aw-1:0] pos_q;
  logic [31:0] count_q;
  logic [15:0] lanes_q;
  logic [15:0] sample_rd;
  logic [31:0] interval_eff;
  logic step;
  logic last;
  logic played_q;

  // interval is clamped to 1..2^31 clocks
  always_comb begin
    if (interval_q == 32'h0000_0000) begin
      interval_eff = 32'h0000_0001;
    end else if (interval_q > interval_max) begin
      interval_eff = interval_max;
    end else begin
      interval_eff = interval_q;
    end
  end

  assign sample_rd = mem[pos_q];
  assign step = state_q == st_run && count_q == 32'h0000_0001;
  assign last = 15'(pos_q) == length_q - 15'h0001;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else if (clk_en) begin
      case (state_q)
        st_idle: begin
          if (start_pulse) begin
            state_q <= st_run;
          end
        end
        st_run: begin
          if (start_pulse) begin
            state_q <= st_run;
          end else if (stop_pulse) begin
            state_q <= st_idle;
          end else if (step && last && !cyclic_q) begin
            state_q <= st_idle;
          end
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // interval counter: reloaded on start and after each sample
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= 32'h0000_0001;
    end else if (clk_en) begin
      if (start_pulse || step) begin
        count_q <= interval_eff;
      end else if (state_q == st_run) begin
        count_q <= count_q - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos_q <= '0;
    end else if (clk_en) begin
      if (start_pulse) begin
        pos_q <= '0;
      end else if (step) begin
        if (last) begin
          pos_q <= '0;
        end else begin
          pos_q <= pos_q + 1'b1;
        end
      end
    end
  end

  // lanes show the initial sample until the first step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lanes_q <= initial_reset;
    end else if (clk_en) begin
      if (state_q == st_idle && !start_pulse && !played_q) begin
        lanes_q <= initial_q;
      end else if (start_pulse) begin
        lanes_q <= initial_q;
      end else if (step) begin
        lanes_q <= sample_rd;
      end
    end
  end

  // after a run the last sample stays until the next start

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      played_q <= 1'b0;
    end else if (clk_en) begin
      if (start_pulse) begin
        played_q <= 1'b1;
      end
    end
  end

  // two-valued lane outputs only, routing to pins is the mux's job
  assign pattern_lane_out = lanes_q;
  // other functions own other pins, nothing here is shared
  assign busy = state_q == st_run;

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_rdata <= 16'h0000;
    end else if (clk_en && bus_req.rd) begin
      if (bus_req.addr == reg_ctrl) begin
        bus_rdata <= {13'h0000, cyclic_q, 2'b00};
      end else if (bus_req.addr == reg_status) begin
        bus_rdata <= {15'h0000, busy};
      end else if (bus_req.addr == reg_initial) begin
        bus_rdata <= initial_q;
      end else if (bus_req.addr == reg_length) begin
        bus_rdata <= {1'b0, length_q};
      end else if (bus_req.addr == reg_interval_lo) begin
        bus_rdata <= interval_q[15:0];
      end else if (bus_req.addr == reg_interval_hi) begin
        bus_rdata <= interval_q[31:16];
      end else if (bus_req.addr == reg_mem_addr) begin
        bus_rdata <= 16'(mem_addr_q);
      end else if (bus_req.addr == reg_mem_data) begin
        bus_rdata <= mem[mem_addr_q];
      end else if (bus_req.addr == reg_position) begin
        bus_rdata <= 16'(pos_q);
      end else begin
        bus_rdata <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_start_busy;
    @(posedge clock) disable iff (rst)
    start_pulse |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

  property p_start_pos;
    @(posedge clock) disable iff (rst)
    start_pulse |=> pos_q == '0;
  endproperty
  a_start_pos: assert property (p_start_pos) else $error("start did not rewind");

  property p_oneshot_end;
    @(posedge clock) disable iff (rst)
    (clk_en && step && last && !cyclic_q && !start_pulse) |=> !busy;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end) else $error("one-shot did not stop");

  property p_hold_last;
    @(posedge clock) disable iff (rst)
    (!busy && $past(!busy) && !$past(start_pulse) && played_q) |-> $stable(pattern_lane_out);
  endproperty
  a_hold_last: assert property (p_hold_last) else $error("lanes moved while stopped");

  property p_cyclic_wrap;
    @(posedge clock) disable iff (rst)
    (clk_en && step && last && cyclic_q && !start_pulse && !stop_pulse) |=> busy && pos_q == '0;
  endproperty
  a_cyclic_wrap: assert property (p_cyclic_wrap) else $error("cyclic did not wrap");

  property p_step_sample;
    @(posedge clock) disable iff (rst)
    (clk_en && step && !start_pulse) |=> pattern_lane_out == $past(sample_rd);
  endproperty
  a_step_sample: assert property (p_step_sample) else $error("lanes not from memory");

  property p_advance;
    @(posedge clock) disable iff (rst)
    (clk_en && step && !last && !start_pulse) |=> pos_q == $past(pos_q) + 1'b1;
  endproperty
  a_advance: assert property (p_advance) else $error("address did not advance");

  property p_first_interval;
    @(posedge clock) disable iff (rst)
    (start_pulse && interval_eff == 32'h0000_0003) |=> !step ##1 !step;
  endproperty
  a_first_interval: assert property (p_first_interval) else $error("sample came early");

  property p_initial_held;
    @(posedge clock) disable iff (rst)
    start_pulse |=> pattern_lane_out == $past(initial_q);
  endproperty
  a_initial_held: assert property (p_initial_held) else $error("initial not shown");

  property p_reload;
    @(posedge clock) disable iff (rst)
    (clk_en && step && !start_pulse) |=> count_q == $past(interval_eff);
  endproperty
  a_reload: assert property (p_reload) else $error("interval not reloaded");

  property p_ivl_range;
    @(posedge clock) disable iff (rst)
    interval_eff != 32'h0000_0000 && interval_eff <= interval_max;
  endproperty
  a_ivl_range: assert property (p_ivl_range) else $error("interval out of range");

  property p_len_range;
    @(posedge clock) disable iff (rst)
    length_q != 15'h0000 && length_q <= 15'(depth);
  endproperty
  a_len_range: assert property (p_len_range) else $error("length out of range");

  property p_stop;
    @(posedge clock) disable iff (rst)
    (stop_pulse && !start_pulse) |=> !busy;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end playback");

  property p_loop;
    @(posedge clock) disable iff (rst)
    (clk_en && busy && cyclic_q && !stop_pulse) |=> busy;
  endproperty
  a_loop: assert property (p_loop) else $error("cyclic playback stopped");

  property p_live_init;
    @(posedge clock) disable iff (rst)
    (clk_en && !busy && !played_q) |=> pattern_lane_out == $past(initial_q);
  endproperty
  a_live_init: assert property (p_live_init) else $error("initial not tracked");
endmodule

`default_nettype wire

// >>> bench/mcu_model.sv
// microcontroller model: master side of the 16-bit register port
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
  input wire logic clock,
  output var pattern_pkg::bus_req_type bus_req,
  input wire logic [15:0] bus_rdata
);
  import pattern_pkg::*;
  initial bus_req = '{addr: 8'h00, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
  // released address and data are inverted so a stale value never looks valid
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
    @(posedge clock);
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

// >>> bench/logic_pattern_unit_tb_top.sv
// testbench: register access and playback of the logic pattern generator
`timescale 1ns/1ps
`default_nettype none
module logic_pattern_unit_tb_top;
  import pattern_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  bus_req_type bus_req;
  logic [15:0] bus_rdata;
  logic [15:0] pattern_lane_out;
  logic busy;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] seg [4] = '{16'h1111, 16'h9999, 16'haaaa, 16'h19af};
  always #2.5 clock = ~clock;
  mcu_model i_mcu (.clock(clock), .bus_req(bus_req), .bus_rdata(bus_rdata));
  logic_pattern_unit #(.depth(64), .aw(6)) i_dut (
    .clock(clock), .rst(rst), .clk_en(clk_en), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .pattern_lane_out(pattern_lane_out), .busy(busy));
  // ----------------------------------------
  // compare helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_mcu.read(a, d);
    chk(d, exp, "register read");
  endtask
  // lanes are looked at 1 ns after the n-th edge, once the edge has landed
  task automatic step(input int n, input logic [15:0] exp);
    repeat (n) @(posedge clock);
    #1;
    chk(pattern_lane_out, exp, "lanes");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    chk(pattern_lane_out, 16'h0000, "reset lanes");
    chk_reg(reg_status, 16'h0000);
    chk_reg(reg_length, 16'h0001);
    chk_reg(reg_interval_lo, 16'h0001);
    chk_reg(reg_interval_hi, 16'h0000);
    chk_reg(reg_initial, 16'h0000);
    i_mcu.write(reg_length, 16'h0000);
    chk_reg(reg_length, 16'h0001);
    i_mcu.write(reg_length, 16'h7fff);
    chk_reg(reg_length, 16'h0040);
    i_mcu.write(reg_interval_hi, 16'h8000);
    i_mcu.write(reg_interval_lo, 16'h0000);
    chk_reg(reg_interval_hi, 16'h8000);
    chk_reg(8'h3f, 16'h0000);
    $display("test reset done");
  endtask
  task automatic test_load;
    i_mcu.write(reg_mem_addr, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      i_mcu.write(reg_mem_data, seg[k]);
    end
    i_mcu.write(reg_mem_addr, 16'h0002);
    chk_reg(reg_mem_data, 16'haaaa);
    chk_reg(reg_mem_addr, 16'h0002);
    $display("test load done");
  endtask
  task automatic test_initial;
    i_mcu.write(reg_initial, 16'h1234);
    step(2, 16'h1234);
    // a strobe under a low enable must be dropped
    @(posedge clock);
    clk_en <= 1'b0;
    i_mcu.write(reg_initial, 16'hffff);
    @(posedge clock);
    clk_en <= 1'b1;
    step(2, 16'h1234);
    $display("test initial done");
  endtask
  task automatic test_oneshot;
    i_mcu.write(reg_length, 16'h0004);
    i_mcu.write(reg_interval_lo, 16'h0002);
    i_mcu.write(reg_interval_hi, 16'h0000);
    i_mcu.write(reg_ctrl, 16'h0001);
    #1;
    chk({15'h0000, busy}, 16'h0001, "busy at start");
    chk(pattern_lane_out, 16'h1234, "initial at start");
    for (int k = 0; k < 4; k++) begin
      step(1, (k == 0) ? 16'h1234 : seg[k-1]);
      step(1, seg[k]);
      chk({15'h0000, busy}, {15'h0000, k < 3}, "busy");
    end
    step(4, seg[3]);
    $display("test oneshot done");
  endtask
  task automatic test_cyclic;
    i_mcu.write(reg_interval_lo, 16'h0000);
    i_mcu.write(reg_ctrl, 16'h0005);
    #1;
    for (int k = 0; k < 9; k++) begin
      step(1, seg[k % 4]);
    end
    i_mcu.write(reg_ctrl, 16'h0005);
    #1;
    chk(pattern_lane_out, 16'h1234, "restart initial");
    step(1, seg[0]);
    step(1, seg[1]);
    i_mcu.write(reg_ctrl, 16'h0002);
    chk_reg(reg_status, 16'h0000);
    $display("test cyclic done");
  endtask
  // interval of three: the first sample lands on the third edge after start
  task automatic test_interval;
    i_mcu.write(reg_interval_lo, 16'h0003);
    i_mcu.write(reg_ctrl, 16'h0004);
    chk_reg(reg_ctrl, 16'h0004);
    i_mcu.write(reg_ctrl, 16'h0001);
    step(2, 16'h1234);
    step(1, seg[0]);
    chk_reg(reg_position, 16'h0001);
    chk_reg(reg_status, 16'h0001);
    step(8, seg[3]);
    chk_reg(reg_status, 16'h0000);
    $display("test interval done");
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_load();
    test_initial();
    test_oneshot();
    test_cyclic();
    test_interval();
    stop_test();
  end
endmodule
`default_nettype wire
